// [logic/pwmp_cfg.svh]
// Constants of the PWM / period counter / prescaler block.
// Assumes AXI4-Lite with 32-bit data; included by package and top.
`ifndef PWMP_CFG_SVH
`define PWMP_CFG_SVH

// ==========================================
// Bus geometry
`define PWMP_AXI_AW         8
`define PWMP_AXI_DW         32

// ==========================================
// Register byte offsets
`define PWMP_OFS_CLOCK      8'h00
`define PWMP_OFS_CTRL       8'h04
`define PWMP_OFS_MASK       8'h08
`define PWMP_OFS_FLAG       8'h0C
`define PWMP_OFS_PERIOD     8'h10
`define PWMP_OFS_DUTY       8'h14
`define PWMP_OFS_ACLR       8'h18
`define PWMP_OFS_AIRQ       8'h1C
`define PWMP_OFS_PCNT       8'h20
`define PWMP_OFS_ACNT       8'h24

// ==========================================
// Field positions
`define PWMP_CLK_MODE_HI    5
`define PWMP_CLK_MODE_LO    4
`define PWMP_CLK_PRE_HI     2
`define PWMP_CTL_OEN        7
`define PWMP_CTL_POL        6
`define PWMP_CTL_IN2_LO     3
`define PWMP_CTL_IN1_LO     0
`define PWMP_MSK_CEN        7
`define PWMP_MSK_IE2        1
`define PWMP_MSK_IE1        0

// ==========================================
// Reset values and responses
`define PWMP_RST_BYTE       8'h00
`define PWMP_RESP_OKAY      2'b00
`define PWMP_RESP_SLVERR    2'b10

`endif

// [logic/pwmp_pkg.sv]
// Types of the PWM / period counter / prescaler block.
// Assumes pwmp_cfg.svh on the include path.
`include "pwmp_cfg.svh"

package pwmp_pkg;

    // ==========================================
    // Counter configurations
    typedef enum logic [1:0] {
        PWMP_MODE_PHASE  = 2'b00,
        PWMP_MODE_DUAL   = 2'b01,
        PWMP_MODE_PERIOD = 2'b10,
        PWMP_MODE_PRESC  = 2'b11
    } pwmp_mode_e;

    // ==========================================
    // AXI4-Lite carriers
    typedef struct packed {
        logic                    awvalid;
        logic [`PWMP_AXI_AW-1:0] awaddr;
        logic                    wvalid;
        logic [`PWMP_AXI_DW-1:0] wdata;
        logic [3:0]              wstrb;
        logic                    bready;
        logic                    arvalid;
        logic [`PWMP_AXI_AW-1:0] araddr;
        logic                    rready;
    } pwmp_axi_req_s;

    typedef struct packed {
        logic                    awready;
        logic                    wready;
        logic                    bvalid;
        logic [1:0]              bresp;
        logic                    arready;
        logic                    rvalid;
        logic [`PWMP_AXI_DW-1:0] rdata;
        logic [1:0]              rresp;
    } pwmp_axi_rsp_s;

endpackage

// [logic/pwmp_top.sv]
// PWM with period counter or clock prescaler, AXI4-Lite register slave.
// Assumes one 50 MHz clock; input pins are asynchronous to it.
//
// Functional notes
// (R1) Mode code 2 selects PWM with period counter.
// (R2) Period mode: accumulator counts only period matches of the PWM counter.
// (R3) Period mode: PWM counter clocked by first input selector.
// (R4) Period match resets output, clears PWM counter, bumps accumulator, event.
// (R5) Duty match changes output state; direction set by polarity.
// (R6) Polarity zero: duty match sets output, period match clears it.
// (R7) Output enable drives the pin with the chosen polarity.
// (R8) Output off: PWM counter still counts, duty value has no effect.
// (R9) Period mode: accumulator clears on match with its clear value.
// (R10) Accumulator equal to interrupt compare raises the accumulator event.
// (R11) Period mode: second input unit inactive, pin left free.
// (R12) First pin as clock counts rising, falling or both edges.
// (R13) Gated bus clock stops counting while pin at active level.
// (R14) Mode code 3 selects PWM with prescaler.
// (R15) Prescaler mode: PWM counter steps only on accumulator clear match.
// (R16) Prescaler mode: accumulator divides second selector clock by 1 to 256.
// (R17) Prescaler mode: accumulator clocked by second input selector.
// (R18) Prescaler mode: period match raises event, clears counter, output low; the code sets the output to the polarity bit instead.
// (R19) Prescale code n gives bus clock divided by two to the n.
// (R20) First selector codes: stop, scaled, gated low/high, fall, rise, both.
// (R21) Enable low holds counters clear and output at inactive level.
// (R22) Clear value zero gives division by 256 in prescaler mode.
// (R23) Each event sets a flag; interrupt needs flag and enable both set.
//
// Added by the designer: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ns
`include "pwmp_cfg.svh"

module pwmp_top #(
    parameter int PRE_W = 7
) (
    // Clock and reset
    input  wire logic                    clock_i,
    input  wire logic                    rst_i,
    // Register bus
    input  wire pwmp_pkg::pwmp_axi_req_s axi_req_i,
    output pwmp_pkg::pwmp_axi_rsp_s      axi_rsp_o,
    // Pins
    input  wire logic                    first_input_pin_i,
    input  wire logic                    second_input_pin_i,
    output logic                         pwm_output_o,
    output logic                         pwm_output_oe_o,
    output logic                         irq_o
);

    // ==========================================
    // Elaboration check
    if (PRE_W < 7) begin : g_bad_pre
        $error("PRE_W must reach a divide by 128");
    end

    // ==========================================
    // State
    typedef struct packed {
        logic [2:0]            sync1;
        logic [2:0]            sync2;
        logic [1:0]            lvl;
        logic [PRE_W-1:0]      div;
        logic [7:0]            clk_reg;
        logic [7:0]            ctl_reg;
        logic [7:0]            msk_reg;
        logic [1:0]            flags;
        logic [7:0]            period_compare;
        logic [7:0]            duty_compare;
        logic [7:0]            accum_clear_compare;
        logic [7:0]            accum_irq_compare;
        logic [7:0]            pwm_counter;
        logic [7:0]            accum_counter;
        logic                  out_lvl;
        logic                  out_oe;
        logic                  irq;
        logic                  aw_full;
        logic [7:0]            aw_addr;
        logic                  w_full;
        logic [7:0]            w_data;
        logic                  w_strb0;
        pwmp_pkg::pwmp_axi_rsp_s rsp;
    } pwmp_state_s;

    pwmp_state_s s_q;
    pwmp_state_s s_d;

    // ==========================================
    // Helpers
    function automatic logic [3:0] reg_index(input logic [7:0] a);
        reg_index = 4'hF;
        if (a[1:0] == 2'b00 && a <= `PWMP_OFS_ACNT) begin
            reg_index = a[5:2];
        end
    endfunction

    function automatic logic sel_tick(input logic [2:0] sel, input logic scaled,
                                      input logic lvl, input logic rise,
                                      input logic fall, input logic second);
        case (sel)
            3'h0:    sel_tick = 1'b0;
            3'h1:    sel_tick = scaled;
            3'h2:    sel_tick = scaled & lvl;                 // [R13]
            3'h3:    sel_tick = scaled & ~lvl;                // [R13]
            3'h4:    sel_tick = fall;                         // [R12]
            3'h5:    sel_tick = rise;                         // [R12]
            default: sel_tick = second ? (sel[0] ? ~lvl : lvl) : (rise | fall);
        endcase
    endfunction

    // ==========================================
    // Next state
    pwmp_pkg::pwmp_mode_e mode;
    logic [1:0]  lvl_n;
    logic [1:0]  rise;
    logic [1:0]  fall;
    logic        scaled;
    logic        cen;
    logic        pol;
    logic        tick1;
    logic        tick2;
    logic        in1_tick;
    logic        in2_tick;
    logic [7:0]  cnt1_n;
    logic [7:0]  cnt2_n;
    logic        pmatch;
    logic        dmatch;
    logic        amatch;
    logic        aevent;
    logic        do_wr;
    logic [3:0]  widx;
    logic [3:0]  ridx;
    logic [1:0]  fclr;
    logic [7:0]  rbyte;

    always_comb begin
        s_d = s_q;
        // Pin synchronisers, three stages
        s_d.sync1 = {s_q.sync1[1:0], first_input_pin_i};
        s_d.sync2 = {s_q.sync2[1:0], second_input_pin_i};
        lvl_n[0] = (s_q.sync1[1] == s_q.sync1[2]) ? s_q.sync1[2] : s_q.lvl[0];
        lvl_n[1] = (s_q.sync2[1] == s_q.sync2[2]) ? s_q.sync2[2] : s_q.lvl[1];
        s_d.lvl = lvl_n;
        rise = lvl_n & ~s_q.lvl;
        fall = ~lvl_n & s_q.lvl;

        mode = pwmp_pkg::pwmp_mode_e'(s_q.clk_reg[`PWMP_CLK_MODE_HI:`PWMP_CLK_MODE_LO]);
        cen  = s_q.msk_reg[`PWMP_MSK_CEN];
        pol  = s_q.ctl_reg[`PWMP_CTL_POL];

        // Time base divider
        s_d.div = cen ? s_q.div + PRE_W'(1) : '0;
        scaled  = cen & (&(s_q.div | ~((PRE_W'(1) << s_q.clk_reg[`PWMP_CLK_PRE_HI:0])
                                       - PRE_W'(1))));       // [R19]

        in1_tick = cen & sel_tick(s_q.ctl_reg[`PWMP_CTL_IN1_LO +: 3], scaled,
                                  lvl_n[0], rise[0], fall[0], 1'b0);   // [R3] [R20]
        in2_tick = cen & sel_tick(s_q.ctl_reg[`PWMP_CTL_IN2_LO +: 3], scaled,
                                  lvl_n[1], rise[1], fall[1], 1'b1);   // [R17]

        // Accumulator counter
        cnt2_n = s_q.accum_counter + 8'h01;
        unique case (mode)
            pwmp_pkg::PWMP_MODE_PHASE:  tick2 = 1'b0;
            pwmp_pkg::PWMP_MODE_DUAL:   tick2 = in2_tick;
            pwmp_pkg::PWMP_MODE_PERIOD: tick2 = 1'b0;             // [R11]
            pwmp_pkg::PWMP_MODE_PRESC:  tick2 = in2_tick;         // [R14] [R17]
        endcase
        // Accumulator advance needs the PWM period match in period mode
        cnt1_n = s_q.pwm_counter + 8'h01;
        unique case (mode)
            pwmp_pkg::PWMP_MODE_PHASE:  tick1 = 1'b0;
            pwmp_pkg::PWMP_MODE_DUAL:   tick1 = in1_tick;
            pwmp_pkg::PWMP_MODE_PERIOD: tick1 = in1_tick;         // [R1] [R3]
            pwmp_pkg::PWMP_MODE_PRESC:  tick1 = 1'b0;
        endcase
        pmatch = tick1 & (cnt1_n == s_q.period_compare);
        if (mode == pwmp_pkg::PWMP_MODE_PERIOD) begin
            tick2 = pmatch;                                       // [R2] [R4]
        end
        amatch = tick2 & (cnt2_n == s_q.accum_clear_compare);     // [R9] [R16] [R22]
        aevent = tick2 & (cnt2_n == s_q.accum_irq_compare);       // [R10]
        if (mode == pwmp_pkg::PWMP_MODE_PRESC) begin
            tick1  = amatch;                                      // [R15]
            pmatch = tick1 & (cnt1_n == s_q.period_compare);
        end
        dmatch = tick1 & (cnt1_n == s_q.duty_compare);            // [R5]

        if (!cen) begin
            s_d.pwm_counter   = 8'h00;                            // [R21]
            s_d.accum_counter = 8'h00;
            s_d.out_lvl       = pol;
        end else begin
            if (tick1) begin
                s_d.pwm_counter = pmatch ? 8'h00 : cnt1_n;        // [R4] [R8] [R18]
            end
            if (tick2) begin
                s_d.accum_counter = amatch ? 8'h00 : cnt2_n;      // [R4] [R9]
            end
            if (pmatch) begin
                s_d.out_lvl = pol;                                // [R4] [R6] [R18]
            end else if (dmatch) begin
                s_d.out_lvl = ~pol;                               // [R5] [R6]
            end
        end
        s_d.out_oe = s_q.ctl_reg[`PWMP_CTL_OEN];                  // [R7]

        // AXI write channel capture
        if (axi_req_i.awvalid && s_q.rsp.awready) begin
            s_d.aw_full = 1'b1;
            s_d.aw_addr = axi_req_i.awaddr;
        end
        if (axi_req_i.wvalid && s_q.rsp.wready) begin
            s_d.w_full  = 1'b1;
            s_d.w_data  = axi_req_i.wdata[7:0];
            s_d.w_strb0 = axi_req_i.wstrb[0];
        end
        if (s_q.rsp.bvalid && axi_req_i.bready) begin
            s_d.rsp.bvalid = 1'b0;
        end
        do_wr = s_q.aw_full & s_q.w_full & ~s_q.rsp.bvalid;
        widx  = reg_index(s_q.aw_addr);
        fclr  = 2'b00;
        if (do_wr) begin
            s_d.aw_full    = 1'b0;
            s_d.w_full     = 1'b0;
            s_d.rsp.bvalid = 1'b1;
            s_d.rsp.bresp  = (widx == 4'hF) ? `PWMP_RESP_SLVERR : `PWMP_RESP_OKAY;
            if (s_q.w_strb0) begin
                unique case (widx)
                    4'h0: s_d.clk_reg = s_q.w_data & 8'h37;
                    4'h1: s_d.ctl_reg = s_q.w_data;
                    4'h2: s_d.msk_reg = s_q.w_data & 8'h83;
                    4'h3: fclr = s_q.w_data[1:0];
                    4'h4: s_d.period_compare = s_q.w_data;
                    4'h5: s_d.duty_compare = s_q.w_data;
                    4'h6: s_d.accum_clear_compare = s_q.w_data;
                    4'h7: s_d.accum_irq_compare = s_q.w_data;
                    default: ;
                endcase
            end
        end

        // Flags: a new event wins over a clear
        s_d.flags = (s_q.flags & ~fclr) | {aevent, pmatch};       // [R23]
        s_d.irq   = |(s_d.flags & s_d.msk_reg[`PWMP_MSK_IE2:`PWMP_MSK_IE1]); // [R23]

        s_d.rsp.awready = ~s_d.aw_full & ~s_d.rsp.bvalid;
        s_d.rsp.wready  = ~s_d.w_full & ~s_d.rsp.bvalid;

        // AXI read channel
        ridx = reg_index(axi_req_i.araddr);
        unique case (ridx)
            4'h0:    rbyte = s_q.clk_reg;
            4'h1:    rbyte = s_q.ctl_reg;
            4'h2:    rbyte = s_q.msk_reg;
            4'h3:    rbyte = {6'h00, s_q.flags};
            4'h4:    rbyte = s_q.period_compare;
            4'h5:    rbyte = s_q.duty_compare;
            4'h6:    rbyte = s_q.accum_clear_compare;
            4'h7:    rbyte = s_q.accum_irq_compare;
            4'h8:    rbyte = s_q.pwm_counter;
            4'h9:    rbyte = s_q.accum_counter;
            default: rbyte = 8'h00;
        endcase
        if (s_q.rsp.rvalid && axi_req_i.rready) begin
            s_d.rsp.rvalid = 1'b0;
        end
        if (axi_req_i.arvalid && s_q.rsp.arready) begin
            s_d.rsp.rvalid = 1'b1;
            s_d.rsp.rdata  = {24'h00_0000, rbyte};
            s_d.rsp.rresp  = (ridx == 4'hF) ? `PWMP_RESP_SLVERR : `PWMP_RESP_OKAY;
        end
        s_d.rsp.arready = ~s_d.rsp.rvalid;
    end

    // ==========================================
    // Registers
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================
    // Outputs
    assign axi_rsp_o       = s_q.rsp;
    assign pwm_output_o    = s_q.out_lvl;                         // [R7]
    assign pwm_output_oe_o = s_q.out_oe;
    assign irq_o           = s_q.irq;

endmodule

// [test/pwmp_assertions.sv]
// Checker for pwmp_top: bus timing and output relations.
// Assumes binding to pwmp_top; sees only its ports.
`timescale 1ns/1ns
module pwmp_assertions (
    // Clock and reset
    input wire logic                    clock_i,
    input wire logic                    rst_i,
    // Register bus
    input wire pwmp_pkg::pwmp_axi_req_s axi_req_i,
    input wire pwmp_pkg::pwmp_axi_rsp_s axi_rsp_o,
    // Pins
    input wire logic                    first_input_pin_i,
    input wire logic                    second_input_pin_i,
    input wire logic                    pwm_output_o,
    input wire logic                    pwm_output_oe_o,
    input wire logic                    irq_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    // ==========================================
    // Output enable moves and interrupt falls only after a register write
    oe_rise_a: assert property ($rose(pwm_output_oe_o) |-> $past(axi_rsp_o.bvalid))
        else $error("output enable rose without a write");
    oe_fall_a: assert property ($fell(pwm_output_oe_o) |-> $past(axi_rsp_o.bvalid))
        else $error("output enable fell without a write");
    irq_fall_a: assert property ($fell(irq_o) |-> axi_rsp_o.bvalid)
        else $error("interrupt fell without a write");

    // ==========================================
    // Bus answers
    write_lat_a: assert property (axi_req_i.awvalid && axi_rsp_o.awready
        && axi_req_i.wvalid && axi_rsp_o.wready |-> ##2 axi_rsp_o.bvalid)
        else $error("write answer late");
    read_lat_a: assert property (axi_req_i.arvalid && axi_rsp_o.arready
        |=> axi_rsp_o.rvalid && axi_rsp_o.rdata[31:8] == 24'h00_0000)
        else $error("read answer late or upper bits set");
    b_done_a: assert property (axi_rsp_o.bvalid && axi_req_i.bready |=> !axi_rsp_o.bvalid)
        else $error("write answer not withdrawn");
    r_done_a: assert property (axi_rsp_o.rvalid && axi_req_i.rready |=> !axi_rsp_o.rvalid)
        else $error("read answer not withdrawn");
    write_block_a: assert property (axi_rsp_o.bvalid |-> !axi_rsp_o.awready
        && !axi_rsp_o.wready)
        else $error("write taken while answer pending");
endmodule

bind pwmp_top pwmp_assertions pwmp_assertions_i (.clock_i(clock_i), .rst_i(rst_i),
    .axi_req_i(axi_req_i), .axi_rsp_o(axi_rsp_o), .first_input_pin_i(first_input_pin_i),
    .second_input_pin_i(second_input_pin_i), .pwm_output_o(pwm_output_o),
    .pwm_output_oe_o(pwm_output_oe_o), .irq_o(irq_o));

// [test/pwmp_pins.sv]
// Partner model: drives the external count and gate pins.
// Assumes pins idle low; pulses outlast the block's synchronisers.
`timescale 1ns/1ns
module pwmp_pins (
    // Clock
    input  wire logic clock_i,
    // Pins
    output logic      first_input_pin_o,
    output logic      second_input_pin_o
);
    initial begin
        first_input_pin_o = 1'b0;
        second_input_pin_o = 1'b0;
    end

    // One pulse on the chosen pins, 4 cycles high, 6 low
    task automatic pulse(input logic [1:0] sel);
        @(posedge clock_i);
        first_input_pin_o <= sel[0];
        second_input_pin_o <= sel[1];
        repeat (4) @(posedge clock_i);
        first_input_pin_o <= 1'b0;
        second_input_pin_o <= 1'b0;
        repeat (6) @(posedge clock_i);
    endtask
endmodule

// [test/tb_top.sv]
// Testbench: register-level tests of pwmp_top in modes 2 and 3.
// Assumes logic/ compiled first and the checker bound to the top.
`timescale 1ns/1ns
`include "pwmp_cfg.svh"
module tb_top;
    localparam logic [1:0] OK = `PWMP_RESP_OKAY;
    logic                    clock_i;
    logic                    rst_i;
    pwmp_pkg::pwmp_axi_req_s req;
    pwmp_pkg::pwmp_axi_rsp_s rsp;
    logic                    pin1;
    logic                    pin2;
    logic                    pwm;
    logic                    oe;
    logic                    irq;
    logic                    pol;
    int                      bad_count;
    int                      cmp_count;
    int                      n;

    pwmp_top pwmp_top_i (.clock_i(clock_i), .rst_i(rst_i), .axi_req_i(req),
        .axi_rsp_o(rsp), .first_input_pin_i(pin1), .second_input_pin_i(pin2),
        .pwm_output_o(pwm), .pwm_output_oe_o(oe), .irq_o(irq));
    pwmp_pins pwmp_pins_i (.clock_i(clock_i), .first_input_pin_o(pin1),
        .second_input_pin_o(pin2));

    initial begin
        clock_i = 1'b0;
        forever #10 clock_i = ~clock_i;
    end

    task automatic summarize();
        if (bad_count == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    // ==========================================
    // Bus cycles
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        @(posedge clock_i);
        req.awvalid <= 1'b1;
        req.awaddr  <= a;
        req.wvalid  <= 1'b1;
        req.wdata   <= {24'h00_0000, d};
        req.bready  <= 1'b1;
        forever begin
            @(posedge clock_i);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
            if (rsp.bvalid) break;
        end
        req.bready <= 1'b0;
        chk("bresp", 32'(er), 32'(rsp.bresp));
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
        @(posedge clock_i);
        req.arvalid <= 1'b1;
        req.araddr  <= a;
        req.rready  <= 1'b1;
        forever begin
            @(posedge clock_i);
            if (rsp.arready) req.arvalid <= 1'b0;
            if (rsp.rvalid) break;
        end
        req.rready <= 1'b0;
        chk($sformatf("rdata %h", a), {24'h00_0000, e}, rsp.rdata);
        chk("rresp", 32'(er), 32'(rsp.rresp));
    endtask

    // Pulse both pins k times, then read both counters
    task automatic run(input int k, input int pc, input int ac);
        repeat (k) pwmp_pins_i.pulse(2'b11);
        rd(`PWMP_OFS_PCNT, 8'(pc), OK);
        rd(`PWMP_OFS_ACNT, 8'(ac), OK);
    endtask

    initial begin
        repeat (20000) @(posedge clock_i);
        bad_count++;
        summarize();
    end

    // ==========================================
    // Tests
    initial begin
        req = '0;
        req.wstrb = 4'hf;
        rst_i = 1'b1;
        bad_count = 0;
        cmp_count = 0;
        repeat (10) @(posedge clock_i);
        rst_i <= 1'b0;
        @(posedge clock_i);
        for (int i = 0; i < 10; i++) rd(8'(4 * i), 8'h00, OK);
        rd(8'h28, 8'h00, `PWMP_RESP_SLVERR);
        wr(8'h29, 8'h01, `PWMP_RESP_SLVERR);
        wr(`PWMP_OFS_CLOCK, 8'h20, OK);
        wr(`PWMP_OFS_PERIOD, 8'h03, OK);
        wr(`PWMP_OFS_DUTY, 8'h02, OK);
        wr(`PWMP_OFS_ACLR, 8'h02, OK);
        wr(`PWMP_OFS_AIRQ, 8'h01, OK);
        for (int c = 4; c < 7; c++) begin
            pol = (c == 6);
            n = (c == 6) ? 8 : 4;
            wr(`PWMP_OFS_MASK, 8'h00, OK);
            wr(`PWMP_OFS_FLAG, 8'h03, OK);
            rd(`PWMP_OFS_PCNT, 8'h00, OK);
            chk("pwm_output", 32'h0000_0000, 32'(pwm));
            wr(`PWMP_OFS_CTRL, {1'b1, pol, 3'b101, 3'(c)}, OK);
            wr(`PWMP_OFS_MASK, 8'h83, OK);
            run(4, n % 3, (n / 3) % 2);
            rd(`PWMP_OFS_FLAG, 8'h03, OK);
            chk("pwm_output", 32'((n % 3 == 2) ^ pol), 32'(pwm));
            chk("oe", 32'h0000_0001, 32'(oe));
            chk("irq", 32'h0000_0001, 32'(irq));
        end
        wr(`PWMP_OFS_FLAG, 8'h01, OK);
        wr(`PWMP_OFS_MASK, 8'h81, OK);
        repeat (2) @(posedge clock_i);
        chk("irq", 32'h0000_0000, 32'(irq));
        wr(`PWMP_OFS_CTRL, 8'h2d, OK);
        run(2, 1, 1);
        chk("oe", 32'h0000_0000, 32'(oe));
        // Scaled clock code 7; first pin idle low, so gating blocks or passes
        wr(`PWMP_OFS_MASK, 8'h00, OK);
        wr(`PWMP_OFS_CLOCK, 8'h27, OK);
        wr(`PWMP_OFS_PERIOD, 8'h01, OK);
        for (int g = 0; g < 4; g++) begin
            wr(`PWMP_OFS_FLAG, 8'h03, OK);
            wr(`PWMP_OFS_CTRL, 8'(g), OK);
            wr(`PWMP_OFS_MASK, 8'h80, OK);
            repeat (300) @(posedge clock_i);
            rd(`PWMP_OFS_FLAG, (g[0] ? 8'h03 : 8'h00), OK);
            wr(`PWMP_OFS_MASK, 8'h00, OK);
        end
        wr(`PWMP_OFS_MASK, 8'h00, OK);
        wr(`PWMP_OFS_CLOCK, 8'h30, OK);
        wr(`PWMP_OFS_CTRL, 8'ha8, OK);
        wr(`PWMP_OFS_PERIOD, 8'h05, OK);
        wr(`PWMP_OFS_ACLR, 8'h03, OK);
        wr(`PWMP_OFS_FLAG, 8'h03, OK);
        wr(`PWMP_OFS_MASK, 8'h83, OK);
        run(7, 2, 1);
        chk("pwm_output", 32'h0000_0001, 32'(pwm));
        run(9, 0, 1);
        chk("pwm_output", 32'h0000_0000, 32'(pwm));
        rd(`PWMP_OFS_FLAG, 8'h03, OK);
        wr(`PWMP_OFS_MASK, 8'h00, OK);
        wr(`PWMP_OFS_ACLR, 8'h00, OK);
        wr(`PWMP_OFS_MASK, 8'h83, OK);
        run(257, 1, 1);
        summarize();
    end
endmodule
